// [hw/overrange_init_power_pkg.sv]
/*
  shared constants and carrier types for the over-range, init-status and power-profile registers.
  assumes one sampling-rate clock and an 8-bit register port with 12-bit addresses.
*/
package overrange_init_power_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] LEVEL_ADDR     = 12'h211;
  localparam logic [ADDR_W-1:0] CONFIG_ADDR    = 12'h213;
  localparam logic [ADDR_W-1:0] INIT_ADDR      = 12'h270;
  localparam logic [ADDR_W-1:0] PROFILE_B_ADDR = 12'h29a;
  localparam logic [ADDR_W-1:0] PROFILE_C_ADDR = 12'h29b;
  localparam logic [ADDR_W-1:0] PROFILE_D_ADDR = 12'h29c;
  localparam logic [ADDR_W-1:0] ALARM_ADDR     = 12'h2c0;

  // reset values
  localparam logic [DATA_W-1:0] LEVEL_RESET     = 8'hf2;
  localparam logic [DATA_W-1:0] CONFIG_RESET    = 8'h07;
  localparam logic [DATA_W-1:0] PROFILE_B_RESET = 8'h0f;
  localparam logic [DATA_W-1:0] PROFILE_C_RESET = 8'h04;
  localparam logic [DATA_W-1:0] PROFILE_D_RESET = 8'h1b;
  localparam logic [DATA_W-1:0] ZERO_BYTE       = 8'h00;

  // profile codes
  localparam logic [DATA_W-1:0] PROFILE_B_LOW  = 8'h06;
  localparam logic [DATA_W-1:0] PROFILE_B_HIGH = 8'h0f;
  localparam logic [DATA_W-1:0] PROFILE_C_LOW  = 8'h00;
  localparam logic [DATA_W-1:0] PROFILE_C_HIGH = 8'h04;
  localparam logic [DATA_W-1:0] PROFILE_D_LOW  = 8'h14;
  localparam logic [DATA_W-1:0] PROFILE_D_HIGH = 8'h1b;

  // field positions
  localparam int OUTPUT_ENABLE_BIT = 3;
  localparam int EXPONENT_LSB      = 0;
  localparam int EXPONENT_W        = 3;
  localparam int INIT_DONE_BIT     = 0;
  localparam int ALARM_BIT         = 0;

  // pulse stretch: base of 4 sampling cycles, shifted by the exponent (max 4 << 7 = 512)
  localparam int          STRETCH_CNT_W = 10;
  localparam logic [STRETCH_CNT_W-1:0] STRETCH_BASE = 10'h004;
  localparam logic [STRETCH_CNT_W-1:0] CNT_ONE      = 10'h001;
  localparam logic [STRETCH_CNT_W-1:0] CNT_ZERO     = 10'h000;

  // level compare: 8-bit level against magnitude scaled so full scale is 256
  localparam int LEVEL_CMP_W = 9;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] power_profile_word_b;
    logic [DATA_W-1:0] power_profile_word_c;
    logic [DATA_W-1:0] power_profile_word_d;
  } power_profile_t;

endpackage

// [hw/pulse_stretch.sv]
/*
  one channel of over-range pulse extension.
  assumes detect is sampled every enabled clock and exponent comes from the config register.
*/
`timescale 1ns/10ps
module pulse_stretch
  import overrange_init_power_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  ce,
  input  wire logic                  detect,
  input  wire logic [EXPONENT_W-1:0] exponent,
  output logic                       active
);

  typedef struct packed {
    logic                     active;
    logic [STRETCH_CNT_W-1:0] cnt;
  } stretch_state_t;

  stretch_state_t s_q;
  stretch_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (detect) begin
      // every new detection restarts the full count
      s_d.active = 1'b1;                                                    // RQ14
      s_d.cnt    = (STRETCH_BASE << exponent) - CNT_ONE;                    // RQ3
    end else if (s_q.cnt != CNT_ZERO) begin
      s_d.cnt = s_q.cnt - CNT_ONE;
    end else begin
      s_d.active = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign active = s_q.active;

endmodule

// [hw/overrange_init_power_regs.sv]
/*
  over-range flag, init-status, power-profile and alarm-summary register group.
  assumes a synchronous register port from the serial interface, samples on the sampling clock,
  and init-done / alarm-pending levels from the blocks that own them.
*/
// Functional notes
// RQ1 - with output enable set, flags follow each channel's detection logic
// RQ2 - with output enable clear, all four flags are held low; reset state
// RQ3 - flags last at least 4 * 2^exponent sampling cycles; exponent resets to 7
// RQ4 - read-only startup-complete bit reads zero after reset, one once init finishes
// RQ5 - host issues only soft reset until it reads startup-complete as one
// RQ6 - profile word b: low power 0x06, high performance 0x0f, reset 0x0f
// RQ7 - profile word c: low power 0x00, high performance 0x04, reset 0x04
// RQ8 - profile word d: low power 0x14, high performance 0x1b, reset 0x1b
// RQ9 - host keeps all profile registers in one consistent mode
// RQ10 - host calibrates after every change of power mode
// RQ11 - host clears calibration and serial link enables before profile writes
// RQ12 - detection fires when sample magnitude reaches the 8-bit level, reset 0xf2
// RQ13 - alarm summary at 0x2c0 reads one in bit 0 while any unmasked alarm pends
// RQ14 - each new detection restarts the stretch count
`timescale 1ns/10ps
module overrange_init_power_regs
  import overrange_init_power_pkg::*;
#(
  parameter int NUM_CHAN = 4,
  parameter int SAMPLE_W = 12
) (
  input  wire logic                               clk,
  input  wire logic                               reset,
  input  wire logic                               ce,
  input  wire reg_req_t                           reg_req,
  output logic          [DATA_W-1:0]              reg_rdata,
  input  wire logic     [NUM_CHAN-1:0][SAMPLE_W-1:0] sample,
  input  wire logic                               init_logic_done,
  input  wire logic                               alarm_pending,
  output logic          [NUM_CHAN-1:0]            overrange_flag,
  output power_profile_t                          power_profile
);

  typedef struct packed {
    logic [DATA_W-1:0]   overrange_level;
    logic [DATA_W-1:0]   overrange_config;
    power_profile_t      profile;
    logic                init_done;
    logic                alarm;
    logic [NUM_CHAN-1:0] flag;
    logic [DATA_W-1:0]   rdata;
  } regs_state_t;

  typedef struct packed {
    logic level;
    logic cfg;
    logic init;
    logic prof_b;
    logic prof_c;
    logic prof_d;
    logic alarm;
  } reg_sel_t;

  regs_state_t s_q;
  regs_state_t s_d;

  logic [NUM_CHAN-1:0]   detect;
  logic [NUM_CHAN-1:0]   stretched;
  logic                  overrange_output_enable;
  logic [EXPONENT_W-1:0] pulse_stretch_exponent;
  reg_sel_t              sel;

  // magnitude scaled so that full scale maps to 256; the most negative code reads as full scale
  function automatic logic [LEVEL_CMP_W-1:0] scaled_mag(input logic [SAMPLE_W-1:0] smp);
    logic [SAMPLE_W-1:0] mag;
    mag = smp[SAMPLE_W-1] ? (~smp + {{(SAMPLE_W-1){1'b0}}, 1'b1}) : smp;
    return mag[SAMPLE_W-1 -: LEVEL_CMP_W];
  endfunction

  // inclusive compare: a sample exactly at the level already counts as over range
  function automatic logic over_level(input logic [SAMPLE_W-1:0] smp,
                                      input logic [DATA_W-1:0]   level);
    return scaled_mag(smp) >= {1'b0, level};
  endfunction

  // one shared decoder keeps the read and write maps from drifting apart;
  // unmapped offsets select nothing, so they read as zero and swallow writes
  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    reg_sel_t dec;
    dec = '0;
    case (addr)
      LEVEL_ADDR: begin
        dec.level = 1'b1;
      end
      CONFIG_ADDR: begin
        dec.cfg = 1'b1;
      end
      INIT_ADDR: begin
        dec.init = 1'b1;
      end
      PROFILE_B_ADDR: begin
        dec.prof_b = 1'b1;
      end
      PROFILE_C_ADDR: begin
        dec.prof_c = 1'b1;
      end
      PROFILE_D_ADDR: begin
        dec.prof_d = 1'b1;
      end
      ALARM_ADDR: begin
        dec.alarm = 1'b1;
      end
      default: begin
        dec = '0;
      end
    endcase
    return dec;
  endfunction

  assign overrange_output_enable = s_q.overrange_config[OUTPUT_ENABLE_BIT];
  assign pulse_stretch_exponent  = s_q.overrange_config[EXPONENT_LSB +: EXPONENT_W];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      assign detect[ch] = over_level(sample[ch], s_q.overrange_level);         // RQ12
      pulse_stretch u_stretch (
        .clk      (clk),
        .reset    (reset),
        .ce       (ce),
        .detect   (detect[ch]),
        .exponent (pulse_stretch_exponent),
        .active   (stretched[ch])
      );
    end
  endgenerate

  assign sel = decode_addr(reg_req.addr);

  always_comb begin
    s_d = s_q;
    // gating is at the output flop so a disable blanks flags on the next edge
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (overrange_output_enable) begin
        s_d.flag[i] = stretched[i];                                               // RQ1
      end else begin
        s_d.flag[i] = 1'b0;                                                       // RQ2
      end
    end
    // latched: once initialisation finishes it stays done until reset
    if (init_logic_done) begin
      s_d.init_done = 1'b1;                                                       // RQ4
    end
    s_d.alarm = alarm_pending;                                                    // RQ13
    // reserved values are stored as written; keeping modes consistent is left to software
    if (reg_req.wr) begin
      if (sel.level) begin
        s_d.overrange_level = reg_req.wdata;                                      // RQ12
      end
      if (sel.cfg) begin
        s_d.overrange_config = reg_req.wdata;                                     // RQ1 RQ3
      end
      if (sel.prof_b) begin
        s_d.profile.power_profile_word_b = reg_req.wdata;                         // RQ6
      end
      if (sel.prof_c) begin
        s_d.profile.power_profile_word_c = reg_req.wdata;                         // RQ7
      end
      if (sel.prof_d) begin
        s_d.profile.power_profile_word_d = reg_req.wdata;                         // RQ8
      end
    end
    // reads take the state before this edge, so a same-cycle write shows up one read later
    if (reg_req.rd) begin
      s_d.rdata = ZERO_BYTE;
      if (sel.level) begin
        s_d.rdata = s_q.overrange_level;
      end
      if (sel.cfg) begin
        s_d.rdata = s_q.overrange_config;
      end
      if (sel.init) begin
        s_d.rdata[INIT_DONE_BIT] = s_q.init_done;                                 // RQ4
      end
      if (sel.prof_b) begin
        s_d.rdata = s_q.profile.power_profile_word_b;
      end
      if (sel.prof_c) begin
        s_d.rdata = s_q.profile.power_profile_word_c;
      end
      if (sel.prof_d) begin
        s_d.rdata = s_q.profile.power_profile_word_d;
      end
      if (sel.alarm) begin
        s_d.rdata[ALARM_BIT] = s_q.alarm;                                         // RQ13
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q.overrange_level              <= LEVEL_RESET;                            // RQ12
      s_q.overrange_config             <= CONFIG_RESET;                           // RQ2 RQ3
      s_q.profile.power_profile_word_b <= PROFILE_B_RESET;                        // RQ6
      s_q.profile.power_profile_word_c <= PROFILE_C_RESET;                        // RQ7
      s_q.profile.power_profile_word_d <= PROFILE_D_RESET;                        // RQ8
      s_q.init_done                    <= 1'b0;                                   // RQ4
      s_q.alarm                        <= 1'b0;
      s_q.flag                         <= '0;
      s_q.rdata                        <= ZERO_BYTE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata      = s_q.rdata;
  assign overrange_flag = s_q.flag;
  assign power_profile  = s_q.profile;

endmodule

// [tb/overrange_init_power_regs_props.sv]
/* assertions on the over-range register group.
   bound to the top; sees its ports only. */
`timescale 1ns/10ps
module overrange_init_power_regs_props
  import overrange_init_power_pkg::*;
#(
  parameter int NUM_CHAN = 4,
  parameter int SAMPLE_W = 12
) (
  input wire logic                              clk,
  input wire logic                              reset,
  input wire logic                              ce,
  input wire reg_req_t                          reg_req,
  input wire logic [DATA_W-1:0]                 reg_rdata,
  input wire logic [NUM_CHAN-1:0][SAMPLE_W-1:0] sample,
  input wire logic                              init_logic_done,
  input wire logic                              alarm_pending,
  input wire logic [NUM_CHAN-1:0]               overrange_flag,
  input wire power_profile_t                    power_profile
);
  // output enable is not a port, so shadow it from the write port
  logic en_q;
  always_ff @(posedge clk)
    if (reset) en_q <= 1'b0;
    else if (ce && reg_req.wr && reg_req.addr == CONFIG_ADDR)
      en_q <= reg_req.wdata[OUTPUT_ENABLE_BIT];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_PROF_RST: assert property ($fell(reset) |-> power_profile ==
    {PROFILE_B_RESET, PROFILE_C_RESET, PROFILE_D_RESET}) else $error("profile reset");
  AST_FLAG_RST: assert property ($fell(reset) |-> overrange_flag == '0) else $error("flag reset");
  AST_PROF_WR: assert property (ce && reg_req.wr && reg_req.addr == PROFILE_C_ADDR |=>
    power_profile.power_profile_word_c == $past(reg_req.wdata)) else $error("profile write");
  AST_INIT_RD: assert property (ce && reg_req.rd && reg_req.addr == INIT_ADDR &&
    $past(init_logic_done && ce && !reset) |=> reg_rdata == 8'h01) else $error("init bit");
  AST_ALARM_RD: assert property (ce && reg_req.rd && reg_req.addr == ALARM_ADDR &&
    $past(ce && !reset) |=> reg_rdata == {7'h00, $past(alarm_pending, 2)}) else $error("alarm");
  AST_FLAG_OFF: assert property (ce && !en_q |=> overrange_flag == '0) else $error("flag off");
  AST_STRETCH: assert property ($rose(overrange_flag[0]) && $past(en_q, 2) |->
    (overrange_flag[0] || !en_q)[*4]) else $error("pulse short");
  AST_DETECT: assert property (ce && en_q && sample[0] == 12'h7ff ##1 ce && en_q |=>
    overrange_flag[0]) else $error("detect missed");
endmodule

// [tb/overrange_host_monitor.sv]
/* host side watcher of the four flag pins.
   records the length of the last completed pulse per channel. */
`timescale 1ns/10ps
module overrange_host_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [3:0]  flag,
  output logic [3:0][9:0] pulse_len_q
);
  logic [3:0][9:0] run_q;
  always_ff @(posedge clk)
    for (int i = 0; i < 4; i++) begin
      if (reset) begin
        run_q[i] <= '0;
        pulse_len_q[i] <= '0;
      end else if (flag[i]) run_q[i] <= run_q[i] + 10'h001;
      else if (run_q[i] != '0) begin
        pulse_len_q[i] <= run_q[i];
        run_q[i] <= '0;
      end
    end
endmodule

// [tb/overrange_init_power_regs_tb.sv]
/* self-checking bench for the over-range register group.
   assumes the package is compiled first; ce drops once to test freezing. */
`timescale 1ns/10ps
module overrange_init_power_regs_tb;
  import overrange_init_power_pkg::*;
  logic             clk = 1'b0;
  logic             ce = 1'b1;
  logic             reset = 1'b1;
  logic             done = 1'b0;
  logic             alm = 1'b0;
  reg_req_t         req = '0;
  logic [7:0]       rdata;
  logic [3:0][11:0] smp = '0;
  logic [3:0]       flag;
  power_profile_t   prof;
  logic [3:0][9:0]  plen;
  int               bad_count = 0;
  int               n_checks = 0;
  always #4 clk = ~clk;
  overrange_init_power_regs DUT (.clk(clk), .reset(reset), .ce(ce), .reg_req(req),
    .reg_rdata(rdata), .sample(smp), .init_logic_done(done), .alarm_pending(alm),
    .overrange_flag(flag), .power_profile(prof));
  overrange_host_monitor host (.clk(clk), .reset(reset), .flag(flag), .pulse_len_q(plen));
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk) req <= '0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] want);
    acc(1'b0, a, 8'h00);
    #1 check({16'h0, rdata}, {16'h0, want});
  endtask
  task automatic det(input int ch, input logic [11:0] v, input int gap);
    @(posedge clk) smp[ch] <= v;
    @(posedge clk) smp[ch] <= 12'h000;
    repeat (gap) @(posedge clk);
    #1;
  endtask
  task automatic t_status();
    rc(INIT_ADDR, 8'h00);
    @(posedge clk) done <= 1'b1;
    rc(INIT_ADDR, 8'h01);
    @(posedge clk) done <= 1'b0;
    acc(1'b1, INIT_ADDR, 8'hff);
    rc(INIT_ADDR, 8'h01);
    rc(LEVEL_ADDR, 8'hf2);
    rc(CONFIG_ADDR, 8'h07);
    rc(12'h3ff, 8'h00);
    rc(ALARM_ADDR, 8'h00);
    @(posedge clk) alm <= 1'b1;
    acc(1'b1, ALARM_ADDR, 8'h00);
    rc(ALARM_ADDR, 8'h01);
  endtask
  task automatic t_profiles();
    logic [23:0] code [2];
    code = '{24'h060014, 24'h0f041b};
    check(prof, 24'h0f041b);
    // calibration and link enables sit outside this block and stay off
    foreach (code[m]) begin
      acc(1'b1, PROFILE_B_ADDR, code[m][23:16]);
      acc(1'b1, PROFILE_C_ADDR, code[m][15:8]);
      acc(1'b1, PROFILE_D_ADDR, code[m][7:0]);
      #1 check(prof, code[m]);
      rc(PROFILE_D_ADDR, code[m][7:0]);
    end
  endtask
  task automatic t_flags();
    acc(1'b1, CONFIG_ADDR, 8'h08);
    det(0, 12'h7ff, 20);
    check({14'h0, plen[0]}, 24'd4);
    acc(1'b1, CONFIG_ADDR, 8'h09);
    det(1, 12'h800, 1);
    det(1, 12'h800, 20);
    check({14'h0, plen[1]}, 24'd11);
    acc(1'b1, LEVEL_ADDR, 8'h80);
    det(2, 12'h3f8, 20);
    check({14'h0, plen[2]}, 24'd0);
    det(2, 12'h400, 20);
    check({14'h0, plen[2]}, 24'd8);
    acc(1'b1, CONFIG_ADDR, 8'h0b);
    det(3, 12'hc00, 3);
    check({20'h0, flag}, 24'h8);
    acc(1'b1, CONFIG_ADDR, 8'h03);
    @(posedge clk) #1 check({20'h0, flag}, 24'h0);
    det(0, 12'h7ff, 3);
    check({20'h0, flag}, 24'h0);
  endtask
  // a pulse caught mid-count must stay frozen while ce is low, then finish
  task automatic t_freeze();
    acc(1'b1, CONFIG_ADDR, 8'h08);
    det(1, 12'h7ff, 2);
    @(posedge clk) ce <= 1'b0;
    repeat (10) @(posedge clk);
    #1 check({23'h0, flag[1]}, 24'h1);
    @(posedge clk) ce <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({23'h0, flag[1]}, 24'h0);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_status();
    t_profiles();
    t_flags();
    t_freeze();
    complete_run();
  end
  initial begin
    // the run needs just under two hundred cycles
    repeat (5000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule
bind overrange_init_power_regs overrange_init_power_regs_props #(.NUM_CHAN(NUM_CHAN),
  .SAMPLE_W(SAMPLE_W)) props (.clk(clk), .reset(reset), .ce(ce), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .sample(sample), .init_logic_done(init_logic_done),
  .alarm_pending(alarm_pending), .overrange_flag(overrange_flag),
  .power_profile(power_profile));
